// [design/sts_pkg.sv]
// Operation
// R01: output below prewarning level sets output warning flag, nothing else
// R02: output below selected threshold pulls reset low; release restarts, sets undervoltage flag
// R03: hysteresis bit makes release use the highest rising threshold
// R04: count every consecutive undervoltage event in init, normal and stop modes
// R05: in normal mode the event counter halts while supply is undervoltage
// R06: fourth consecutive event enters fail-safe and sets undervoltage failsafe flag
// R07: counter clears on fail-safe entry, undervoltage flag clear, or soft reset
// R08: no warning or undervoltage flags while in sleep mode
// R09: software should clear warning and undervoltage flags to recheck the condition
// R10: overvoltage crossing sets flag, raises selected event; mode 11 forces fail-safe
// R11: overvoltage detection only while the main regulator is enabled
// R12: short-circuit detection only while supply is above its undervoltage threshold
// R13: output not above reset threshold within short-circuit time triggers shutdown response
// R14: same response when output stays below reset threshold too long
// R15: hot pump sets flags, clears enable, discharges gates, then stops pump and amplifier
// R16: software clears diagnosis flags and rewrites pump enable after cool-down
// R17: regulator prewarning temperature sets flag; clear only once heat has gone
// R18: device shutdown enters fail-safe, waits cool-down, then restarts automatically
// R19: shutdown flag set each event; clear only in normal mode without heat
// R20: with delay bit, count events; at 16 set safe flag, cool-down 64x
// R21: extended wait until safe flag cleared; counter clears with flag or delay bit (code clears it on a shutdown flag clear, not a safe flag clear)
// R22: shutdown sets failure bit and device state 01, even during sleep entry
// R23: flags stay latched until cleared; clear fails while condition persists
package sts_pkg;

  // ==========================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned T_SC_NS = 2000;
  localparam int unsigned SC_CYC = (T_SC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned T_CCP_NS = 587;
  localparam int unsigned CCP_CYC = (T_CCP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned T_COOL_US = 1000;
  localparam int unsigned COOL_DEF_CYC = T_COOL_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned COOL_MULT = 64;
  localparam int unsigned COOL_W = 24;
  localparam int unsigned SC_W = 12;
  localparam int unsigned CCP_W = 8;

  // ==========================================================
  // counters and codes
  localparam logic [2:0] UV_FS_COUNT = 3'h4;
  localparam logic [4:0] TSD_SAFE_COUNT = 5'h10;
  localparam logic [1:0] OV_MODE_FS = 2'h3;
  localparam logic [1:0] DEV_STATE_TSD = 2'h1;
  localparam logic [1:0] DEV_STATE_RST = 2'h0;

  // ==========================================================
  // flag bit positions
  localparam int unsigned NF = 11;
  localparam int unsigned F_WARN = 0;
  localparam int unsigned F_UV = 1;
  localparam int unsigned F_UV_FS = 2;
  localparam int unsigned F_OV = 3;
  localparam int unsigned F_SC = 4;
  localparam int unsigned F_BLK_SD = 5;
  localparam int unsigned F_PUMP_OVERTEMPERATURE_FLAG = 6;
  localparam int unsigned F_T_PREW = 7;
  localparam int unsigned F_T_SD = 8;
  localparam int unsigned F_T_SAFE = 9;
  localparam int unsigned F_FAIL = 10;

  // ==========================================================
  // synchroniser lanes
  localparam int unsigned NS = 9;

  typedef enum logic [5:0] {
    MD_INIT = 6'h01,
    MD_NORMAL = 6'h02,
    MD_STOP = 6'h04,
    MD_SLEEP = 6'h08,
    MD_RESTART = 6'h10,
    MD_FAILSAFE = 6'h20
  } sts_mode_e;

  typedef enum logic [2:0] {
    TS_IDLE = 3'h1,
    TS_HOT = 3'h2,
    TS_COOL = 3'h4
  } sts_therm_e;

endpackage

// [design/sts_sync.sv]
`timescale 1ns/1ps
module sts_sync import sts_pkg::*; #(
  parameter int unsigned W = NS
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sts_sync_s;

  sts_sync_s q;
  sts_sync_s next_q;

  always_comb begin
    next_q.meta = d_in;
    next_q.stable = q.meta;
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign q_out = q.stable;
endmodule

// [design/sts_timer.sv]
`timescale 1ns/1ps
module sts_timer import sts_pkg::*; #(
  parameter int unsigned W = COOL_W
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic load_in,
  input wire logic run_in,
  input wire logic [W-1:0] value_in,
  output logic done_out
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } sts_timer_s;

  sts_timer_s q;
  sts_timer_s next_q;

  // done fires once, on the last counted cycle
  always_comb begin
    next_q = q;
    if (load_in) begin
      next_q.cnt = value_in;
    end else if (run_in && q.cnt != '0) begin
      next_q.cnt = q.cnt - W'(1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign done_out = run_in && !load_in && q.cnt == W'(1);
endmodule

// [design/sts_supervisor.sv]
`timescale 1ns/1ps
module sts_supervisor import sts_pkg::*; #(
  parameter int unsigned COOL_CYC = COOL_DEF_CYC
) (
  input wire logic CORE_CLK_IN,
  input wire logic NRST_IN,
  input wire sts_mode_e MODE_IN,
  input wire logic OUT_BELOW_WARN_IN,
  input wire logic OUT_BELOW_RT_IN,
  input wire logic OUT_ABOVE_RT_IN,
  input wire logic OUT_ABOVE_RT1_IN,
  input wire logic OUT_OVER_IN,
  input wire logic SUPPLY_UV_IN,
  input wire logic PUMP_HOT_IN,
  input wire logic REG_PREWARN_HOT_IN,
  input wire logic DEVICE_HOT_IN,
  input wire logic RESET_HYS_IN,
  input wire logic [1:0] OV_MODE_IN,
  input wire logic SD_DELAY_IN,
  input wire logic PUMP_EN_SET_IN,
  input wire logic SOFT_RESET_IN,
  input wire logic WAKE_IN,
  input wire logic [NF-1:0] CLEAR_IN,
  output logic [NF-1:0] FLAGS_OUT,
  output logic RESET_N_OUT,
  output logic RESET_OE_N_OUT,
  output logic REG_EN_OUT,
  output logic FAIL_PIN_OUT,
  output logic FAILSAFE_REQ_OUT,
  output logic RESTART_REQ_OUT,
  output logic OV_EVT_OUT,
  output logic [1:0] OV_EVT_KIND_OUT,
  output logic PUMP_EN_OUT,
  output logic PUMP_RUN_OUT,
  output logic DISCHARGE_OUT,
  output logic CSA_OFF_OUT,
  output logic [1:0] DEVICE_STATE_OUT,
  output logic [2:0] UV_COUNT_OUT,
  output logic [4:0] SD_COUNT_OUT
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [NF-1:0] flags;
    logic rst_lvl;
    logic rst_oe_n;
    logic reg_en;
    logic fail_pin;
    logic fs_req;
    logic restart_req;
    logic ov_evt;
    logic [1:0] ov_kind;
    logic ov_prev;
    logic pump_en;
    logic pump_run;
    logic disch;
    logic csa_off;
    logic [CCP_W-1:0] disch_cnt;
    logic [1:0] dev_state;
    logic [2:0] uv_cnt;
    logic [4:0] sd_cnt;
    sts_therm_e ts;
  } sts_state_s;

  sts_state_s q;
  sts_state_s next_q;

  // ==========================================================
  // pin inputs
  logic [NS-1:0] sync_q;
  logic s_warn;
  logic s_below_rt;
  logic s_above_rt;
  logic s_above_rt1;
  logic s_ov;
  logic s_sup_uv;
  logic s_pump_hot;
  logic s_prew;
  logic s_hot;

  sts_sync #(.W(NS)) u_sync (
    .clk_in(CORE_CLK_IN),
    .nrst_in(NRST_IN),
    .d_in({DEVICE_HOT_IN, REG_PREWARN_HOT_IN, PUMP_HOT_IN, SUPPLY_UV_IN, OUT_OVER_IN,
           OUT_ABOVE_RT1_IN, OUT_ABOVE_RT_IN, OUT_BELOW_RT_IN, OUT_BELOW_WARN_IN}),
    .q_out(sync_q)
  );

  assign {s_hot, s_prew, s_pump_hot, s_sup_uv, s_ov, s_above_rt1, s_above_rt, s_below_rt,
          s_warn} = sync_q;

  // ==========================================================
  // timers
  logic sc_arm;
  logic sc_done;
  logic cool_load;
  logic cool_done;
  logic [COOL_W-1:0] cool_val;

  sts_timer #(.W(SC_W)) u_sc_timer (
    .clk_in(CORE_CLK_IN),
    .nrst_in(NRST_IN),
    .load_in(!sc_arm),
    .run_in(sc_arm),
    .value_in(SC_W'(SC_CYC)),
    .done_out(sc_done)
  );

  sts_timer #(.W(COOL_W)) u_cool_timer (
    .clk_in(CORE_CLK_IN),
    .nrst_in(NRST_IN),
    .load_in(cool_load),
    .run_in(q.ts == TS_COOL),
    .value_in(cool_val),
    .done_out(cool_done)
  );

  // extension holds as long as the safe flag stands
  assign cool_val = q.flags[F_T_SAFE] ? COOL_W'(COOL_CYC * COOL_MULT) : COOL_W'(COOL_CYC); // R20 R21

  // ==========================================================
  // next state
  logic reg_on;
  logic uv_counting;
  logic rise_ok;
  logic sd_event;
  logic [NF-1:0] set_f;
  logic [NF-1:0] hold_f;
  logic [NF-1:0] allow_f;
  logic [NF-1:0] clr_ok;

  // regulator off in sleep or after a short-circuit shutdown
  assign reg_on = q.reg_en && MODE_IN != MD_SLEEP;
  // reloads while the rail supply is low, so no false short-circuit
  assign sc_arm = reg_on && !s_sup_uv && !s_above_rt; // R12 R13 R14

  always_comb begin
    next_q = q;
    next_q.fs_req = 1'b0;
    next_q.restart_req = 1'b0;
    next_q.ov_evt = 1'b0;
    cool_load = 1'b0;
    sd_event = 1'b0;
    set_f = '0;
    uv_counting = (MODE_IN == MD_INIT || MODE_IN == MD_STOP ||
                   (MODE_IN == MD_NORMAL && !s_sup_uv)); // R04 R05
    rise_ok = RESET_HYS_IN ? s_above_rt1 : s_above_rt; // R03

    // clears fail while the cause is still present
    hold_f = '0;
    hold_f[F_WARN] = s_warn;
    hold_f[F_UV] = s_below_rt;
    hold_f[F_OV] = s_ov;
    hold_f[F_SC] = !q.reg_en;
    hold_f[F_BLK_SD] = s_pump_hot;
    hold_f[F_PUMP_OVERTEMPERATURE_FLAG] = s_pump_hot;
    hold_f[F_T_PREW] = s_prew; // R17
    hold_f[F_T_SD] = s_hot; // R19
    allow_f = '1;
    allow_f[F_T_SD] = MODE_IN == MD_NORMAL; // R19
    clr_ok = CLEAR_IN & allow_f & ~hold_f; // R23

    // output undervoltage and reset
    if (MODE_IN == MD_FAILSAFE || clr_ok[F_UV] || SOFT_RESET_IN) begin
      next_q.uv_cnt = 3'h0; // R07
    end
    if (reg_on && s_warn) begin
      set_f[F_WARN] = 1'b1; // R01 R08
    end
    if (q.rst_oe_n && reg_on && s_below_rt) begin
      next_q.rst_oe_n = 1'b0; // R02
      if (uv_counting) begin
        if (q.uv_cnt == UV_FS_COUNT - 3'h1) begin
          next_q.uv_cnt = 3'h0; // R07
          next_q.fs_req = 1'b1; // R06
          set_f[F_UV_FS] = 1'b1; // R06
        end else begin
          next_q.uv_cnt = q.uv_cnt + 3'h1; // R04
        end
      end
    end else if (!q.rst_oe_n && rise_ok) begin
      next_q.rst_oe_n = 1'b1; // R02
      next_q.restart_req = 1'b1; // R02
      set_f[F_UV] = MODE_IN != MD_SLEEP; // R02 R08
    end

    // overvoltage, rising crossing only
    next_q.ov_prev = s_ov;
    if (reg_on && s_ov && !q.ov_prev) begin
      set_f[F_OV] = 1'b1; // R10 R11
      next_q.ov_evt = 1'b1; // R10
      next_q.ov_kind = OV_MODE_IN; // R10
      if (OV_MODE_IN == OV_MODE_FS) begin
        next_q.fs_req = 1'b1; // R10
      end
    end

    // short circuit
    if (sc_done) begin
      set_f[F_SC] = 1'b1; // R13 R14
      set_f[F_FAIL] = 1'b1; // R13
      next_q.reg_en = 1'b0; // R13
      next_q.fail_pin = 1'b1; // R13
      next_q.fs_req = 1'b1; // R13
    end else if (WAKE_IN && !q.reg_en) begin
      next_q.reg_en = 1'b1;
      next_q.fail_pin = 1'b0;
    end

    // charge pump overheating
    if (q.pump_en && s_pump_hot) begin
      set_f[F_PUMP_OVERTEMPERATURE_FLAG] = 1'b1; // R15
      set_f[F_BLK_SD] = 1'b1; // R15
      next_q.pump_en = 1'b0; // R15
      next_q.disch = 1'b1; // R15
      next_q.disch_cnt = CCP_W'(CCP_CYC);
    end else if (q.disch) begin
      next_q.disch_cnt = q.disch_cnt - CCP_W'(1);
      if (q.disch_cnt == CCP_W'(1)) begin
        next_q.disch = 1'b0; // R15
        next_q.csa_off = 1'b1; // R15
      end
    end else if (PUMP_EN_SET_IN) begin
      // only a fresh write brings the pump back
      next_q.pump_en = 1'b1; // R16
      next_q.csa_off = 1'b0;
    end

    if (s_prew) begin
      set_f[F_T_PREW] = 1'b1; // R17
    end

    // device thermal shutdown
    unique case (q.ts)
      TS_IDLE: begin
        sd_event = s_hot;
      end
      TS_HOT: begin
        if (!s_hot) begin
          next_q.ts = TS_COOL; // R18
          cool_load = 1'b1; // R18
        end
      end
      TS_COOL: begin
        if (s_hot) begin
          sd_event = 1'b1;
        end else if (cool_done) begin
          next_q.ts = TS_IDLE;
          next_q.restart_req = 1'b1; // R18
        end
      end
    endcase

    if (!SD_DELAY_IN || clr_ok[F_T_SD]) begin
      next_q.sd_cnt = 5'h0; // R21
    end
    // taken in any mode, sleep entry included
    if (sd_event) begin
      next_q.ts = TS_HOT;
      next_q.fs_req = 1'b1; // R18 R22
      set_f[F_T_SD] = 1'b1; // R19
      set_f[F_FAIL] = 1'b1; // R22
      next_q.dev_state = DEV_STATE_TSD; // R22
      if (SD_DELAY_IN && q.sd_cnt != TSD_SAFE_COUNT) begin
        next_q.sd_cnt = q.sd_cnt + 5'h1; // R20
        if (q.sd_cnt == TSD_SAFE_COUNT - 5'h1) begin
          set_f[F_T_SAFE] = 1'b1; // R20
        end
      end
    end
    if (clr_ok[F_FAIL]) begin
      next_q.dev_state = DEV_STATE_RST;
    end

    // registered so the run pin cannot glitch between enable and discharge
    next_q.pump_run = next_q.pump_en || next_q.disch; // R15

    // set beats a clear in the same cycle
    for (int i = 0; i < NF; i++) begin
      next_q.flags[i] = set_f[i] || (q.flags[i] && !clr_ok[i]); // R23
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!NRST_IN) begin
      q <= '0;
      q.reg_en <= 1'b1;
      q.ts <= TS_IDLE;
    end else begin
      q <= next_q;
    end
  end

  // ==========================================================
  // outputs
  assign FLAGS_OUT = q.flags;
  assign RESET_N_OUT = q.rst_lvl;
  assign RESET_OE_N_OUT = q.rst_oe_n;
  assign REG_EN_OUT = q.reg_en;
  assign FAIL_PIN_OUT = q.fail_pin;
  assign FAILSAFE_REQ_OUT = q.fs_req;
  assign RESTART_REQ_OUT = q.restart_req;
  assign OV_EVT_OUT = q.ov_evt;
  assign OV_EVT_KIND_OUT = q.ov_kind;
  assign PUMP_EN_OUT = q.pump_en;
  assign PUMP_RUN_OUT = q.pump_run;
  assign DISCHARGE_OUT = q.disch;
  assign CSA_OFF_OUT = q.csa_off;
  assign DEVICE_STATE_OUT = q.dev_state;
  assign UV_COUNT_OUT = q.uv_cnt;
  assign SD_COUNT_OUT = q.sd_cnt;
endmodule

// [verification/sts_supervisor_chk.sv]
`timescale 1ns/1ps
module sts_supervisor_chk import sts_pkg::*; (
  input wire logic CORE_CLK_IN,
  input wire logic NRST_IN,
  input wire sts_mode_e MODE_IN,
  input wire logic SD_DELAY_IN,
  input wire logic [NF-1:0] FLAGS_OUT,
  input wire logic REG_EN_OUT,
  input wire logic FAIL_PIN_OUT,
  input wire logic FAILSAFE_REQ_OUT,
  input wire logic OV_EVT_OUT,
  input wire logic [1:0] OV_EVT_KIND_OUT,
  input wire logic PUMP_EN_OUT,
  input wire logic DISCHARGE_OUT,
  input wire logic CSA_OFF_OUT,
  input wire logic [1:0] DEVICE_STATE_OUT,
  input wire logic [2:0] UV_COUNT_OUT,
  input wire logic [4:0] SD_COUNT_OUT
);
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!NRST_IN);
  // ==========
  // discharge length, too long for a repetition
  logic [7:0] dis_cnt;
  always_ff @(posedge CORE_CLK_IN) begin
    dis_cnt <= DISCHARGE_OUT ? dis_cnt + 8'h1 : 8'h0;
  end
  sequence s_pump_trip;
    $rose(DISCHARGE_OUT);
  endsequence
  sequence s_pump_safe;
    !PUMP_EN_OUT && FLAGS_OUT[F_PUMP_OVERTEMPERATURE_FLAG] && FLAGS_OUT[F_BLK_SD];
  endsequence
  // ==========
  // properties
  a_ov_flag_evt: assert property ($rose(FLAGS_OUT[F_OV]) |-> OV_EVT_OUT)
    else $error("overvoltage flag without event");
  a_ov_mode_fs: assert property (OV_EVT_OUT && OV_EVT_KIND_OUT == OV_MODE_FS |-> FAILSAFE_REQ_OUT)
    else $error("overvoltage mode 3 without fail-safe request");
  a_ov_reg_on: assert property (OV_EVT_OUT |-> $past(REG_EN_OUT))
    else $error("overvoltage event with regulator off");
  a_sc_response: assert property ($rose(FLAGS_OUT[F_SC]) |->
    !REG_EN_OUT && FAIL_PIN_OUT && FLAGS_OUT[F_FAIL] && FAILSAFE_REQ_OUT)
    else $error("short circuit response incomplete");
  a_uv_fs_entry: assert property ($rose(FLAGS_OUT[F_UV_FS]) |->
    FAILSAFE_REQ_OUT && UV_COUNT_OUT == 3'h0)
    else $error("undervoltage fail-safe entry wrong");
  a_uv_count_max: assert property (UV_COUNT_OUT < UV_FS_COUNT)
    else $error("undervoltage counter past limit");
  a_fs_clr_cnt: assert property (MODE_IN == MD_FAILSAFE |=> UV_COUNT_OUT == 3'h0)
    else $error("undervoltage counter kept in fail-safe");
  a_pump_trip: assert property (s_pump_trip |-> s_pump_safe)
    else $error("pump trip without flags or enable clear");
  a_pump_done: assert property ($fell(DISCHARGE_OUT) |-> dis_cnt == CCP_CYC && CSA_OFF_OUT)
    else $error("discharge length or amplifier off wrong");
  a_tsd_entry: assert property ($rose(FLAGS_OUT[F_T_SD]) |->
    FLAGS_OUT[F_FAIL] && DEVICE_STATE_OUT == DEV_STATE_TSD && FAILSAFE_REQ_OUT)
    else $error("thermal shutdown entry wrong");
  a_sd_cnt_off: assert property (!SD_DELAY_IN |=> SD_COUNT_OUT == 5'h0)
    else $error("shutdown counter kept without delay bit");
  a_safe_at16: assert property ($rose(FLAGS_OUT[F_T_SAFE]) |-> SD_COUNT_OUT == TSD_SAFE_COUNT)
    else $error("thermal safe flag at wrong count");
endmodule

bind sts_supervisor sts_supervisor_chk u_chk (.CORE_CLK_IN, .NRST_IN, .MODE_IN, .SD_DELAY_IN,
  .FLAGS_OUT, .REG_EN_OUT, .FAIL_PIN_OUT, .FAILSAFE_REQ_OUT, .OV_EVT_OUT, .OV_EVT_KIND_OUT,
  .PUMP_EN_OUT, .DISCHARGE_OUT, .CSA_OFF_OUT, .DEVICE_STATE_OUT, .UV_COUNT_OUT, .SD_COUNT_OUT);

// [verification/sts_mcu_model.sv]
`timescale 1ns/1ps
module sts_mcu_model import sts_pkg::*; (
  input wire logic clk_in,
  input wire logic [NF-1:0] flags_in,
  input wire logic [NF-1:0] mask_in,
  input wire logic clear_req_in,
  input wire logic pump_req_in,
  output logic [NF-1:0] clear_out,
  output logic pump_set_out
);
  // ==========
  // software side: clears only flags it has read, one-cycle strobes
  initial begin
    clear_out = '0;
    pump_set_out = 1'b0;
  end
  always @(negedge clk_in) begin
    clear_out <= clear_req_in ? flags_in & mask_in : '0;
    pump_set_out <= pump_req_in;
  end
endmodule

// [verification/sts_supervisor_tb.sv]
`timescale 1ns/1ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin fails++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
module sts_supervisor_tb import sts_pkg::*;;
  localparam int unsigned COOL = 20;
  logic clk, nrst, blw, brt, art, art1, ovr, suv, phot, rhot, dhot, hys, sdd, srst, wake;
  logic creq, preq, pset, ren, fpin, fsr, rsr, oen, ovev, pen, dis, csa, rpin, prun;
  logic [1:0] ovm, kind, dst;
  logic [2:0] uvc;
  logic [4:0] sdc;
  logic [NF-1:0] msk, clr, f;
  sts_mode_e md;
  int fails, checked, cyc;

  sts_supervisor #(.COOL_CYC(COOL)) uut (.CORE_CLK_IN(clk), .NRST_IN(nrst), .MODE_IN(md),
    .OUT_BELOW_WARN_IN(blw), .OUT_BELOW_RT_IN(brt), .OUT_ABOVE_RT_IN(art),
    .OUT_ABOVE_RT1_IN(art1), .OUT_OVER_IN(ovr), .SUPPLY_UV_IN(suv), .PUMP_HOT_IN(phot),
    .REG_PREWARN_HOT_IN(rhot), .DEVICE_HOT_IN(dhot), .RESET_HYS_IN(hys), .OV_MODE_IN(ovm),
    .SD_DELAY_IN(sdd), .PUMP_EN_SET_IN(pset), .SOFT_RESET_IN(srst), .WAKE_IN(wake),
    .CLEAR_IN(clr), .FLAGS_OUT(f), .RESET_N_OUT(rpin), .RESET_OE_N_OUT(oen), .REG_EN_OUT(ren),
    .FAIL_PIN_OUT(fpin), .FAILSAFE_REQ_OUT(fsr), .RESTART_REQ_OUT(rsr), .OV_EVT_OUT(ovev),
    .OV_EVT_KIND_OUT(kind), .PUMP_EN_OUT(pen), .PUMP_RUN_OUT(prun), .DISCHARGE_OUT(dis),
    .CSA_OFF_OUT(csa), .DEVICE_STATE_OUT(dst), .UV_COUNT_OUT(uvc), .SD_COUNT_OUT(sdc));
  sts_mcu_model u_mcu (.clk_in(clk), .flags_in(f), .mask_in(msk), .clear_req_in(creq),
    .pump_req_in(preq), .clear_out(clr), .pump_set_out(pset));

  initial clk = 1'b0;
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      end_sim();
    end
  end
  // ==========
  // helpers
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic clear(input logic [NF-1:0] m);
    msk <= m;
    creq <= 1'b1;
    tick(1);
    creq <= 1'b0;
    tick(3);
  endtask
  task automatic pump;
    preq <= 1'b1;
    tick(1);
    preq <= 1'b0;
    tick(3);
  endtask
  task automatic end_sim;
    if (fails == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ==========
  // scenarios
  task automatic t_warn;
    blw <= 1'b1;
    tick(4);
    `CHK("warn", 11'h001, f)
    clear(11'h001);
    `CHK("warn_held", 1'b1, f[F_WARN])
    blw <= 1'b0;
    tick(4);
    clear(11'h001);
    `CHK("warn_clr", 1'b0, f[F_WARN])
    md <= MD_SLEEP;
    blw <= 1'b1;
    tick(5);
    `CHK("warn_sleep", 1'b0, f[F_WARN])
    blw <= 1'b0;
    md <= MD_NORMAL;
    tick(4);
  endtask
  task automatic uv_evt(input logic h);
    brt <= 1'b1;
    art <= 1'b0;
    art1 <= 1'b0;
    tick(4);
    `CHK("rst_low", 1'b0, oen)
    `CHK("rst_pin", 1'b0, rpin)
    brt <= 1'b0;
    art <= 1'b1;
    tick(4);
    `CHK("rst_hys", ~h, oen)
    art1 <= 1'b1;
    tick(4);
  endtask
  task automatic t_uv;
    uv_evt(1'b0);
    `CHK("uv_flag", 1'b1, f[F_UV])
    `CHK("uv_cnt1", 3'h1, uvc)
    clear(11'h002);
    `CHK("uv_clr", 3'h0, uvc)
    hys <= 1'b1;
    uv_evt(1'b1);
    srst <= 1'b1;
    tick(1);
    srst <= 1'b0;
    tick(2);
    `CHK("uv_srst", 3'h0, uvc)
    suv <= 1'b1;
    uv_evt(1'b1);
    `CHK("uv_halt", 3'h0, uvc)
    suv <= 1'b0;
    md <= MD_INIT;
    uv_evt(1'b1);
    md <= MD_STOP;
    repeat (2) uv_evt(1'b1);
    `CHK("uv_cnt3", 3'h3, uvc)
    uv_evt(1'b1);
    `CHK("uv_fs", 1'b1, f[F_UV_FS])
    `CHK("uv_cnt0", 3'h0, uvc)
    md <= MD_NORMAL;
    hys <= 1'b0;
    clear(11'h006);
  endtask
  task automatic t_ov;
    int n;
    for (int m = 0; m < 4; m++) begin
      ovm <= 2'(m);
      ovr <= 1'b1;
      n = 0;
      while (ovev !== 1'b1 && n < 8) begin
        tick(1);
        n++;
      end
      `CHK("ov_evt", 1'b1, ovev)
      `CHK("ov_kind", 2'(m), kind)
      `CHK("ov_fs", (m == 3), fsr)
      `CHK("ov_flag", 1'b1, f[F_OV])
      ovr <= 1'b0;
      tick(4);
      clear(11'h008);
    end
  endtask
  task automatic t_sc;
    md <= MD_FAILSAFE;
    suv <= 1'b1;
    brt <= 1'b1;
    art <= 1'b0;
    art1 <= 1'b0;
    tick(300);
    `CHK("sc_supply", 1'b0, f[F_SC])
    suv <= 1'b0;
    tick(SC_CYC + 4);
    `CHK("sc_reg", 1'b0, ren)
    `CHK("sc_pin", 1'b1, fpin)
    `CHK("sc_flags", 2'b11, {f[F_FAIL], f[F_SC]})
    ovr <= 1'b1;
    tick(5);
    `CHK("ov_off", 1'b0, f[F_OV])
    ovr <= 1'b0;
    wake <= 1'b1;
    tick(1);
    wake <= 1'b0;
    tick(SC_CYC - 10);
    `CHK("sc_early", 1'b1, ren)
    tick(14);
    `CHK("sc_again", 2'b01, {ren, fpin})
    brt <= 1'b0;
    art <= 1'b1;
    art1 <= 1'b1;
    wake <= 1'b1;
    tick(1);
    wake <= 1'b0;
    tick(4);
    md <= MD_NORMAL;
    clear(11'h7ff);
    `CHK("sc_clr", 11'h000, f)
  endtask
  task automatic t_pump;
    pump();
    `CHK("pump_on", 1'b1, pen)
    phot <= 1'b1;
    tick(4);
    `CHK("pump_trip", 2'b10, {dis, pen})
    `CHK("pump_run", 1'b1, prun)
    pump();
    tick(CCP_CYC);
    `CHK("pump_off", 3'b010, {dis, csa, pen})
    `CHK("pump_stop", 1'b0, prun)
    clear(11'h060);
    `CHK("pump_held", 2'b11, f[6:5])
    phot <= 1'b0;
    tick(4);
    clear(11'h060);
    pump();
    `CHK("pump_back", 3'b001, {f[6:5], pen})
  endtask
  task automatic t_therm;
    int n;
    int lim;
    rhot <= 1'b1;
    tick(4);
    clear(11'h080);
    `CHK("prew_held", 1'b1, f[F_T_PREW])
    rhot <= 1'b0;
    tick(4);
    clear(11'h080);
    `CHK("prew_clr", 1'b0, f[F_T_PREW])
    sdd <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      dhot <= 1'b1;
      tick(4);
      if (i == 0) begin
        `CHK("tsd_set", 4'hd, {f[F_T_SD], f[F_FAIL], dst})
        md <= MD_FAILSAFE;
      end
      dhot <= 1'b0;
      n = 0;
      while (rsr !== 1'b1 && n < 2000) begin
        tick(1);
        n++;
      end
      lim = (i == 15) ? COOL * COOL_MULT : COOL;
      `CHK("cool", 1'b1, n >= lim && n <= lim + 8)
      if (i == 0) begin
        clear(11'h100);
        `CHK("tsd_fs_clr", 1'b1, f[F_T_SD])
        md <= MD_NORMAL;
      end
    end
    `CHK("sd_cnt", 6'h30, {f[F_T_SAFE], sdc})
    sdd <= 1'b0;
    tick(2);
    `CHK("sd_cnt_clr", 5'h00, sdc)
    clear(11'h700);
    `CHK("tsd_clr", 11'h000, f)
  endtask
  // ==========
  // main sequence
  initial begin
    {nrst, blw, brt, ovr, suv, phot, rhot, dhot, hys, sdd, srst, wake, creq, preq} = '0;
    {art, art1} = 2'b11;
    ovm = 2'h0;
    msk = '0;
    md = MD_INIT;
    fails = 0;
    checked = 0;
    cyc = 0;
    tick(20);
    nrst <= 1'b1;
    md <= MD_NORMAL;
    tick(6);
    clear(11'h7ff);
    `CHK("rst_flags", 11'h000, f)
    `CHK("rst_reg", 1'b1, ren)
    t_warn();
    t_uv();
    t_ov();
    t_sc();
    t_pump();
    t_therm();
    end_sim();
  end
endmodule
